// file: shared/oac_pkg.sv
// Constants for the octal converter serial output control block
package oac_pkg;
    localparam int          NUM_CH          = 8;
    localparam int          WORD_BITS       = 10;
    localparam int          HALF_STAGES     = 13;
    localparam int          FRAME_HIGH_BITS = 5;
    localparam int          SERIAL_MULT     = 5;
    localparam int          SLOTS_PER_FRAME = 2 * SERIAL_MULT;
    localparam int          FIFO_DEPTH      = 8;
    localparam int          PERIOD_BITS     = 16;

    // Fixed test word, MSB to LSB 0001011101
    localparam logic [9:0]  TEST_WORD       = 10'h05D;

    // Clock and reference settling time
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          SETTLE_MS       = 100;
    localparam int          SETTLE_CYCLES   = SETTLE_MS * 1000000 / CLK_PERIOD_NS;

    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam logic [11:0] ADDR_PERIOD     = 12'h008;

    // Control register fields
    localparam int          CTRL_TEST_BIT   = 0;
    localparam int          CTRL_PD_BIT     = 1;
    localparam int          CTRL_FMT_BIT    = 2;
    localparam int          CTRL_PLL_LSB    = 4;
    localparam logic [6:0]  CTRL_RESET      = 7'h00;

    // Status register fields
    localparam int          STAT_SETTLED_BIT = 0;
    localparam int          STAT_OVF_BIT     = 1;
    localparam int          STAT_PD_BIT      = 2;

    typedef enum logic [0:0] {
        SER_IDLE  = 1'b0,
        SER_SHIFT = 1'b1
    } oac_ser_state_t;
endpackage

// file: logic/oac_serial_ctrl.sv
// Octal converter output framing, serializer, FIFO and APB control registers
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps


module oac_fifo #(
    parameter int WIDTH = 80,
    parameter int DEPTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

module oac_serial_ctrl #(
    parameter int SETTLE_CYCLES = oac_pkg::SETTLE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sample_clock_in,
    input  wire logic [79:0] conversion_code,
    output logic             serial_clock_out_pos,
    output logic             serial_clock_out_neg,
    output logic             frame_align_out_pos,
    output logic             frame_align_out_neg,
    output logic [7:0]       channel_data_out_pos,
    output logic [7:0]       channel_data_out_neg,
    output logic             result_valid
);
    localparam int NCH = oac_pkg::NUM_CH;
    localparam int WB  = oac_pkg::WORD_BITS;
    localparam int HS  = oac_pkg::HALF_STAGES;
    localparam int PB  = oac_pkg::PERIOD_BITS;
    localparam int FW  = NCH * WB;

    // Control and status state
    logic [6:0]    ctrl;
    logic          overflow;
    logic [31:0]   settle_cnt;
    logic          settled;
    logic          test_pattern_enable;
    logic          global_power_down;
    logic          format_offset_binary;
    logic [2:0]    pll_range_select;

    // Sample clock synchroniser and edge detect
    logic          sclk_meta;
    logic          sclk_sync;
    logic          sclk_prev;
    logic          sclk_rise;
    logic          sclk_fall;
    logic [PB-1:0] period_cnt;
    logic [PB-1:0] period;

    // Half-period pipeline
    logic [FW-1:0] pipe_data [HS];
    logic [HS-1:0] pipe_valid;
    logic [FW-1:0] formatted;

    // FIFO
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic [FW-1:0] fifo_out_data;
    logic          push_req;

    // Serializer
    oac_pkg::oac_ser_state_t ser_state;
    logic [PB-1:0] slot_acc;
    logic [PB-1:0] next_slot_acc;
    logic          slot;
    logic [3:0]    bit_idx;
    logic [FW-1:0] shift_word;

    // APB decode
    logic          apb_setup;
    logic          apb_access;
    logic          addr_hit;

    assign test_pattern_enable  = ctrl[oac_pkg::CTRL_TEST_BIT];
    assign global_power_down    = ctrl[oac_pkg::CTRL_PD_BIT];
    assign format_offset_binary = ctrl[oac_pkg::CTRL_FMT_BIT];
    assign pll_range_select     = ctrl[oac_pkg::CTRL_PLL_LSB +: 3];

    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;
    assign addr_hit   = (paddr == oac_pkg::ADDR_CTRL) || (paddr == oac_pkg::ADDR_STATUS)
                        || (paddr == oac_pkg::ADDR_PERIOD);
    assign pready     = penable;
    assign pslverr    = apb_access && !addr_hit;

    // Control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= oac_pkg::CTRL_RESET;
        end else if (apb_access && pwrite && paddr == oac_pkg::ADDR_CTRL) begin
            ctrl <= pwdata[6:0];
        end
    end

    // Overflow flag, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow <= 1'b0;
        end else if (push_req && !fifo_in_ready) begin
            overflow <= 1'b1;
        end else if (apb_access && pwrite && paddr == oac_pkg::ADDR_STATUS
                     && pwdata[oac_pkg::STAT_OVF_BIT]) begin
            overflow <= 1'b0;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_setup && !pwrite) begin
            unique case (paddr)
                oac_pkg::ADDR_CTRL: begin
                    prdata <= {25'h0000000, ctrl};
                end
                oac_pkg::ADDR_STATUS: begin
                    prdata <= {29'h00000000, global_power_down, overflow, settled};
                end
                oac_pkg::ADDR_PERIOD: begin
                    prdata <= {16'h0000, period};
                end
                default: begin
                    prdata <= '0;
                end
            endcase
        end
    end

    // Reference settling counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 32'(SETTLE_CYCLES);
        end else if (global_power_down) begin
            settle_cnt <= 32'(SETTLE_CYCLES);
        end else if (settle_cnt != '0) begin
            settle_cnt <= settle_cnt - 1'b1;
        end
    end

    assign settled      = (settle_cnt == '0);
    assign result_valid = settled && !global_power_down;

    // Sample clock crossing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_prev <= 1'b0;
        end else begin
            sclk_meta <= sample_clock_in;
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
        end
    end

    assign sclk_rise = sclk_sync && !sclk_prev;
    assign sclk_fall = !sclk_sync && sclk_prev;

    // Sample period measured between rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt <= '0;
            period     <= '0;
        end else if (sclk_rise) begin
            period_cnt <= PB'(1);
            period     <= period_cnt;
        end else if (period_cnt != '1) begin
            period_cnt <= period_cnt + 1'b1;
        end
    end

    // Per-channel format and test word selection
    generate
        for (genvar ch = 0; ch < NCH; ch++) begin : g_fmt
            always_comb begin
                if (test_pattern_enable) begin
                    formatted[ch*WB +: WB] = oac_pkg::TEST_WORD;
                end else if (format_offset_binary) begin
                    formatted[ch*WB +: WB] = conversion_code[ch*WB +: WB];
                end else begin
                    formatted[ch*WB +: WB] = {~conversion_code[ch*WB + WB - 1],
                                              conversion_code[ch*WB +: WB - 1]};
                end
            end
        end
    endgenerate

    // Pipeline shifts on both sample clock edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_valid <= '0;
        end else if (global_power_down) begin
            pipe_valid <= '0;
        end else if (sclk_rise || sclk_fall) begin
            pipe_valid <= {pipe_valid[HS-2:0], sclk_rise};
        end
    end

    generate
        for (genvar st = 0; st < HS; st++) begin : g_pipe
            always_ff @(posedge pclk) begin
                if (sclk_rise || sclk_fall) begin
                    if (st == 0) begin
                        pipe_data[st] <= formatted;
                    end else begin
                        pipe_data[st] <= pipe_data[st-1];
                    end
                end
            end
        end
    endgenerate

    // Word leaves the last stage 13 half periods after sampling
    assign push_req = (sclk_rise || sclk_fall) && pipe_valid[HS-1]
                      && !global_power_down;

    oac_fifo #(
        .WIDTH (FW),
        .DEPTH (oac_pkg::FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (global_power_down),
        .in_valid  (push_req),
        .in_ready  (fifo_in_ready),
        .in_data   (pipe_data[HS-1]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Bit slot rate: ten slots per measured sample period of ten pclk or more, else one slot every pclk
    always_comb begin
        next_slot_acc = slot_acc + PB'(oac_pkg::SLOTS_PER_FRAME);
        slot          = 1'b0;
        if (next_slot_acc >= period) begin
            slot          = 1'b1;
            next_slot_acc = next_slot_acc - period;
        end
        if (next_slot_acc >= period) begin
            next_slot_acc = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_acc <= '0;
        end else if (global_power_down || period == '0) begin
            slot_acc <= '0;
        end else begin
            slot_acc <= next_slot_acc;
        end
    end

    // Pop a new word at the end of each frame or from idle
    assign fifo_out_ready = slot && !global_power_down
                            && (ser_state == oac_pkg::SER_IDLE
                                || bit_idx == 4'(WB - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_state  <= oac_pkg::SER_IDLE;
            bit_idx    <= '0;
            shift_word <= '0;
        end else if (global_power_down) begin
            ser_state  <= oac_pkg::SER_IDLE;
            bit_idx    <= '0;
        end else if (slot) begin
            unique case (ser_state)
                oac_pkg::SER_IDLE: begin
                    if (fifo_out_valid) begin
                        ser_state  <= oac_pkg::SER_SHIFT;
                        shift_word <= fifo_out_data;
                        bit_idx    <= '0;
                    end
                end
                oac_pkg::SER_SHIFT: begin
                    if (bit_idx == 4'(WB - 1)) begin
                        bit_idx <= '0;
                        if (fifo_out_valid) begin
                            shift_word <= fifo_out_data;
                        end else begin
                            ser_state <= oac_pkg::SER_IDLE;
                        end
                    end else begin
                        bit_idx <= bit_idx + 1'b1;
                    end
                end
            endcase
        end
    end

    // Registered lane, clock and frame outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_clock_out_pos <= 1'b0;
            serial_clock_out_neg <= 1'b1;
            frame_align_out_pos  <= 1'b0;
            frame_align_out_neg  <= 1'b1;
            channel_data_out_pos <= '0;
            channel_data_out_neg <= '1;
        end else if (global_power_down) begin
            serial_clock_out_pos <= 1'b0;
            serial_clock_out_neg <= 1'b1;
            frame_align_out_pos  <= 1'b0;
            frame_align_out_neg  <= 1'b1;
            channel_data_out_pos <= '0;
            channel_data_out_neg <= '1;
        end else if (slot) begin
            if (fifo_out_ready && fifo_out_valid) begin
                // First slot of a frame carries bit 0 with frame rising
                serial_clock_out_pos <= 1'b1;
                serial_clock_out_neg <= 1'b0;
                frame_align_out_pos  <= 1'b1;
                frame_align_out_neg  <= 1'b0;
                for (int ch = 0; ch < NCH; ch++) begin
                    channel_data_out_pos[ch] <= fifo_out_data[ch*WB];
                    channel_data_out_neg[ch] <= ~fifo_out_data[ch*WB];
                end
            end else if (ser_state == oac_pkg::SER_SHIFT && bit_idx != 4'(WB - 1)) begin
                serial_clock_out_pos <= bit_idx[0];
                serial_clock_out_neg <= ~bit_idx[0];
                frame_align_out_pos  <= (bit_idx + 1'b1) < 4'(oac_pkg::FRAME_HIGH_BITS);
                frame_align_out_neg  <= !((bit_idx + 1'b1) < 4'(oac_pkg::FRAME_HIGH_BITS));
                for (int ch = 0; ch < NCH; ch++) begin
                    channel_data_out_pos[ch] <= shift_word[ch*WB + int'(bit_idx) + 1];
                    channel_data_out_neg[ch] <= ~shift_word[ch*WB + int'(bit_idx) + 1];
                end
            end else begin
                serial_clock_out_pos <= 1'b0;
                serial_clock_out_neg <= 1'b1;
                frame_align_out_pos  <= 1'b0;
                frame_align_out_neg  <= 1'b1;
            end
        end
    end
endmodule

// file: tb/oac_serial_ctrl_checker.sv
// Port checker for the octal converter serial output control block
`timescale 1ns/100ps
module oac_serial_ctrl_checker #(
    parameter int SETTLE_CYCLES = 50
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_clock_in,
    input wire logic [79:0] conversion_code,
    input wire logic        serial_clock_out_pos,
    input wire logic        serial_clock_out_neg,
    input wire logic        frame_align_out_pos,
    input wire logic        frame_align_out_neg,
    input wire logic [7:0]  channel_data_out_pos,
    input wire logic [7:0]  channel_data_out_neg,
    input wire logic        result_valid
);
    logic        pd_q;
    logic        clk_q;
    logic        frm_q;
    logic        seen;
    logic [3:0]  slot_q;
    logic [31:0] settle_cnt;
    logic        access;
    logic        mapped;
    logic        frm_rise;
    logic        clk_chg;
    localparam int LAT_MIN = 52; // 6.5 sample periods of 8 pclk

    assign access   = psel && penable;
    assign mapped   = paddr == oac_pkg::ADDR_CTRL || paddr == oac_pkg::ADDR_STATUS
                      || paddr == oac_pkg::ADDR_PERIOD;
    assign frm_rise = frame_align_out_pos && !frm_q;
    assign clk_chg  = serial_clock_out_pos != clk_q;

    // Power-down level as written over the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_q <= 1'b0;
        end else if (access && pwrite && paddr == oac_pkg::ADDR_CTRL) begin
            pd_q <= pwdata[oac_pkg::CTRL_PD_BIT];
        end
    end

    // Cycles since reset or power-down release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 32'h0;
        end else if (pd_q) begin
            settle_cnt <= 32'h0;
        end else if (settle_cnt != 32'hFFFFFFFF) begin
            settle_cnt <= settle_cnt + 32'h1;
        end
    end

    // Slot index within the current word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q  <= 1'b0;
            frm_q  <= 1'b0;
            slot_q <= 4'h0;
            seen   <= 1'b0;
        end else begin
            clk_q <= serial_clock_out_pos;
            frm_q <= frame_align_out_pos;
            seen  <= result_valid && (seen || frm_rise);
            if (frm_rise) begin
                slot_q <= 4'h0;
            end else if (clk_chg) begin
                slot_q <= slot_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pairs_complement_a: assert property (serial_clock_out_neg == !serial_clock_out_pos
        && frame_align_out_neg == !frame_align_out_pos
        && channel_data_out_neg == ~channel_data_out_pos) else $error("pair not complementary");
    ready_zero_wait_a: assert property (access |-> pready)
        else $error("pready low in access cycle");
    mapped_no_error_a: assert property (access && mapped |-> !pslverr)
        else $error("error on mapped address");
    unmapped_read_a: assert property (access && !mapped && !pwrite |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    frame_start_a: assert property (frm_rise |-> serial_clock_out_pos && !clk_q)
        else $error("frame rise not on first bit slot");
    frame_slots_a: assert property (seen && clk_chg && !frm_rise
        |-> frame_align_out_pos == (slot_q < 4'h4)) else $error("frame level wrong for slot");
    word_length_a: assert property (seen && frm_rise |-> slot_q == 4'h9)
        else $error("word not ten slots long");
    frame_sync_a: assert property (!pd_q && $changed(frame_align_out_pos) |-> clk_chg)
        else $error("frame moved between slots");
    pd_quiet_a: assert property (pd_q [*3] |-> channel_data_out_pos == 8'h00
        && !frame_align_out_pos && !result_valid) else $error("outputs active in power-down");
    settle_early_a: assert property (result_valid |-> settle_cnt >= SETTLE_CYCLES - 2)
        else $error("valid before reference settled");
    settle_late_a: assert property (settle_cnt == SETTLE_CYCLES + 4 |-> result_valid)
        else $error("valid late after settling");
    word_latency_a: assert property (frm_rise && settle_cnt < 32'h64
        |-> settle_cnt >= LAT_MIN) else $error("word out before pipeline latency");

    cover property (seen && frm_rise);
    cover property (pd_q [*3]);
    cover property (access && !mapped);
    cover property ($rose(result_valid));
endmodule

bind oac_serial_ctrl oac_serial_ctrl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_checker (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_clock_in(sample_clock_in), .conversion_code(conversion_code),
    .serial_clock_out_pos(serial_clock_out_pos), .serial_clock_out_neg(serial_clock_out_neg),
    .frame_align_out_pos(frame_align_out_pos), .frame_align_out_neg(frame_align_out_neg),
    .channel_data_out_pos(channel_data_out_pos), .channel_data_out_neg(channel_data_out_neg),
    .result_valid(result_valid)
);

// file: tb/oac_rx_model.sv
// Deserializing receiver model for the eight serial lanes
`timescale 1ns/100ps
module oac_rx_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        serial_clock_out_pos,
    input wire logic        frame_align_out_pos,
    input wire logic [7:0]  channel_data_out_pos,
    input wire logic        result_valid,
    output logic     [79:0] rx_word,
    output logic     [15:0] rx_count
);
    logic        clk_q;
    logic        frm_q;
    logic [3:0]  idx;
    logic [3:0]  next_idx;
    logic [79:0] acc;
    logic [79:0] next_acc;

    // Realign on every frame rise
    always_comb begin
        next_idx = (frame_align_out_pos && !frm_q) ? 4'h0 : idx + 4'h1;
        next_acc = acc;
        for (int n = 0; n < 8; n++) begin
            if (next_idx < 4'hA) next_acc[10 * n + next_idx] = channel_data_out_pos[n];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_q <= 1'b0;
            frm_q <= 1'b0;
            idx <= 4'hF;
            acc <= 80'h0;
            rx_word <= 80'h0;
            rx_count <= 16'h0;
        end else if (serial_clock_out_pos != clk_q) begin
            clk_q <= serial_clock_out_pos;
            idx <= next_idx;
            frm_q <= frame_align_out_pos;
            acc <= next_acc;
            // Words outside the settled state are dropped
            if (next_idx == 4'h9 && result_valid) begin
                rx_word <= next_acc;
                rx_count <= rx_count + 16'h1;
            end
        end
    end
endmodule

// file: tb/oac_serial_ctrl_test.sv
// Testbench for the octal converter serial output control block
`timescale 1ns/100ps
module oac_serial_ctrl_test;
    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sample_clock_in;
    logic [79:0] conversion_code;
    logic        sclk_p;
    logic        sclk_n;
    logic        frm_p;
    logic        frm_n;
    logic [7:0]  lane_p;
    logic [7:0]  lane_n;
    logic        result_valid;
    logic [79:0] rx_word;
    logic [15:0] rx_count;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          checks;
    int          cycles;

    oac_serial_ctrl #(.SETTLE_CYCLES(50)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_clock_in(sample_clock_in),
        .conversion_code(conversion_code), .serial_clock_out_pos(sclk_p),
        .serial_clock_out_neg(sclk_n), .frame_align_out_pos(frm_p),
        .frame_align_out_neg(frm_n), .channel_data_out_pos(lane_p),
        .channel_data_out_neg(lane_n), .result_valid(result_valid)
    );

    oac_rx_model i_rx (
        .pclk(pclk), .presetn(presetn), .serial_clock_out_pos(sclk_p),
        .frame_align_out_pos(frm_p), .channel_data_out_pos(lane_p),
        .result_valid(result_valid), .rx_word(rx_word), .rx_count(rx_count)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Free sample clock, even duty, phase unrelated to pclk
    initial begin
        sample_clock_in = 1'b0;
        #13;
        forever #160 sample_clock_in = ~sample_clock_in;
    end

    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [79:0] expect_of(input logic [79:0] raw, input logic [31:0] ctl);
        logic [79:0] r;
        logic [9:0]  w;
        for (int n = 0; n < 8; n++) begin
            w = raw[10 * n +: 10];
            if (ctl[0]) w = 10'h05D;
            else if (!ctl[2]) w[9] = ~w[9];
            r[10 * n +: 10] = w;
        end
        return r;
    endfunction

    // New codes and control, then compare a word once old words have drained
    task automatic run_case(input logic [9:0] base, input logic [31:0] ctl);
        logic [79:0] raw;
        logic [15:0] start;
        for (int n = 0; n < 8; n++) raw[10 * n +: 10] = base + 10'(n * 73);
        @(posedge pclk);
        conversion_code <= raw;
        apb(oac_pkg::ADDR_CTRL, 1'b1, ctl);
        start = rx_count;
        while (16'(rx_count - start) < 16'h0018) @(posedge pclk);
        for (int n = 0; n < 8; n++) begin
            chk("lane word", 32'(expect_of(raw, ctl) >> (10 * n)) & 32'h3FF,
                32'(rx_word >> (10 * n)) & 32'h3FF);
        end
    endtask

    initial begin
        presetn = 1'b0;
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        conversion_code = 80'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(oac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("settled early", 32'h0, rd & 32'h1);
        apb(oac_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(12'h00C, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        repeat (60) @(posedge pclk);
        apb(oac_pkg::ADDR_STATUS, 1'b1, 32'h0);
        apb(oac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("settled", 32'h1, rd & 32'h1);
        apb(oac_pkg::ADDR_CTRL, 1'b1, 32'h74);
        apb(oac_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl readback", 32'h74, rd);
        run_case(10'h2A5, 32'h74);
        run_case(10'h3FF, 32'h70);
        run_case(10'h15A, 32'h71);
        run_case(10'h000, 32'h75);
        apb(oac_pkg::ADDR_PERIOD, 1'b0, 32'h0);
        chk("period", 32'h8, rd);
        apb(oac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("overflow", 32'h2, rd & 32'h2);
        apb(oac_pkg::ADDR_CTRL, 1'b1, 32'h72);
        repeat (4) @(posedge pclk);
        chk("pd lanes", 32'h0, 32'(lane_p));
        chk("pd valid", 32'h0, 32'(result_valid));
        apb(oac_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("pd status", 32'h4, rd & 32'h5);
        apb(oac_pkg::ADDR_CTRL, 1'b1, 32'h70);
        repeat (3) @(posedge pclk);
        chk("valid after pd", 32'h0, 32'(result_valid));
        repeat (60) @(posedge pclk);
        chk("valid settled", 32'h1, 32'(result_valid));
        run_case(10'h1C3, 32'h74);
        print_verdict();
    end
endmodule
